//--- sim/tb_top.sv
// Self-checking bench for the device control registers driven over the serial port.
`timescale 1ns/1ps

module tb_top
  import cgd_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h2a;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl_in = 1'b1;
  logic msda = 1'b1;
  wire sda_in;
  logic sda_out;
  logic sda_oe_n;
  logic divider_sync_pulse;
  logic pll_reacquire_trigger;
  logic bias_calibration_trigger;
  logic [3:0] bank_enables;
  cgd_bank_src_t bank_src = '0;
  logic pdd = 1'b0;
  logic pds = 1'b0;
  cgd_bank_out_t bank_out;
  int failures = 0;
  int checked = 0;
  int n_p[3];
  int e_p[3];
  logic [31:0] seed = 32'h2a79e35e;
  logic [3:0] en_m = 4'hf;
  logic [7:0] d;

  // The wire is pulled up; the device can only pull it low, and only where its level is 0.
  assign sda_in = msda & (sda_oe_n | sda_out);

  // Free-running core clock.
  always #5 clk = ~clk;

  cgd_device_ctrl #(.DEV_ADDR(ADDR)) i_cgd_device_ctrl (
    .clk(clk),
    .nrst(nrst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .bank_src(bank_src),
    .fourth_bank_powerdown(pdd),
    .single_ended_output_powerdown(pds),
    .divider_sync_pulse(divider_sync_pulse),
    .pll_reacquire_trigger(pll_reacquire_trigger),
    .bias_calibration_trigger(bias_calibration_trigger),
    .bank_enables(bank_enables),
    .bank_out(bank_out)
  );

  // Count every cycle a command pulse stands high, so a stretched pulse shows up.
  always @(posedge clk)
  begin
    if (divider_sync_pulse === 1'b1) n_p[0]++;
    if (pll_reacquire_trigger === 1'b1) n_p[1]++;
    if (bias_calibration_trigger === 1'b1) n_p[2]++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  // Gated levels expected one cycle after the given inputs.
  function automatic cgd_bank_out_t exp_out(input logic [3:0] en, input cgd_bank_src_t s,
                                            input logic pd, input logic ps);
    cgd_bank_out_t o;
    o.first_bank_outputs = en[3] ? s.a : 4'h0;
    o.first_bank_outputs_comp = ~o.first_bank_outputs;
    o.second_bank_outputs = en[2] ? s.b : 4'h0;
    o.second_bank_outputs_comp = ~o.second_bank_outputs;
    o.third_bank_outputs = en[1] ? s.c : 2'h0;
    o.third_bank_outputs_comp = ~o.third_bank_outputs;
    o.fourth_bank_diff_output = en[0] & s.d0;
    o.fourth_bank_diff_output_comp = ~o.fourth_bank_diff_output;
    o.fourth_bank_single_output = en[0] & s.d1;
    o.fourth_bank_single_oe_n = pd | ps;
    return o;
  endfunction : exp_out

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One bus bit; SCL phases stay well above the four-cycle minimum.
  task automatic cbit(input logic b, output logic r);
    tick(1);
    msda <= b;
    tick(6);
    scl_in <= 1'b1;
    tick(3);
    @(negedge clk);
    r = sda_in;
    tick(3);
    scl_in <= 1'b0;
  endtask : cbit

  task automatic start_cond;
    tick(1);
    msda <= 1'b1;
    tick(4);
    scl_in <= 1'b1;
    tick(5);
    msda <= 1'b0;
    tick(5);
    scl_in <= 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    tick(1);
    msda <= 1'b0;
    tick(4);
    scl_in <= 1'b1;
    tick(5);
    msda <= 1'b1;
    tick(5);
  endtask : stop_cond

  task automatic tx(input logic [7:0] b, input logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) cbit(b[i], r);
    cbit(1'b1, r);
    chk("ack", 32'(nak), 32'(r));
  endtask : tx

  task automatic rd(input logic [7:0] ra, output logic [7:0] q);
    logic r;
    start_cond();
    tx({ADDR, 1'b0}, 1'b0);
    tx(ra, 1'b0);
    start_cond();
    tx({ADDR, 1'b1}, 1'b0);
    for (int i = 7; i >= 0; i--)
    begin
      cbit(1'b1, r);
      q[i] = r;
    end
    cbit(1'b1, r);
    stop_cond();
  endtask : rd

  // Write bytes from ra upward and advance the model the same way.
  task automatic wr(input logic [7:0] ra, input logic [7:0] q[$]);
    logic [7:0] a;
    start_cond();
    tx({ADDR, 1'b0}, 1'b0);
    tx(ra, 1'b0);
    foreach (q[i]) tx(q[i], 1'b0);
    stop_cond();
    foreach (q[i])
    begin
      a = ra + 8'(i);
      if (a >= 8'h3d && a <= 8'h3f && q[i][7]) e_p[a - 8'h3d]++;
      if (a == 8'h40) en_m = q[i][3:0];
    end
    tick(10);
  endtask : wr

  task automatic chk_p;
    for (int i = 0; i < 3; i++) chk("pulse_count", 32'(e_p[i]), 32'(n_p[i]));
  endtask : chk_p

  // Random sources and powerdowns each cycle; the undriven single output is masked.
  task automatic gate(input int n);
    cgd_bank_src_t s;
    logic pd;
    logic ps;
    cgd_bank_out_t eo;
    logic [31:0] m;
    s = bank_src;
    pd = pdd;
    ps = pds;
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk);
      eo = exp_out(en_m, s, pd, ps);
      seed = lfsr(lfsr(seed));
      s = seed[11:0];
      pd = seed[12] & seed[13];
      ps = seed[14] & seed[15];
      bank_src <= s;
      pdd <= pd;
      pds <= ps;
      @(negedge clk);
      m = eo.fourth_bank_single_oe_n ? 32'hfffffffd : 32'hffffffff;
      chk("bank_out", 32'(eo) & m, 32'(bank_out) & m);
    end
  endtask : gate

  // Main sequence.
  initial
  begin
    tick(2);
    nrst <= 1'b1;
    tick(5);
    chk("enables", 32'h0f, 32'(bank_enables));
    for (int a = 0; a < 4; a++)
    begin
      rd(8'h3d + 8'(a), d);
      chk("readback", (a == 3) ? 32'h0f : 32'h0, 32'(d));
    end
    gate(20);
    for (int a = 0; a < 3; a++)
    begin
      wr(8'h3d + 8'(a), '{8'h00});
      chk_p();
      wr(8'h3d + 8'(a), '{8'h80});
      chk_p();
      rd(8'h3d + 8'(a), d);
      chk("readback", 32'h0, 32'(d));
    end
    wr(8'h3d, '{8'h80, 8'h80, 8'h80, 8'h0a});
    chk_p();
    chk("enables", 32'(en_m), 32'(bank_enables));
    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      wr(8'h40, '{{4'h0, seed[3:0]}});
      rd(8'h40, d);
      chk("readback", 32'(en_m), 32'(d));
      gate(30);
    end
    // An unmapped register takes no write and reads back as zero.
    wr(8'h41, '{8'h05});
    rd(8'h41, d);
    chk("readback", 32'h0, 32'(d));
    start_cond();
    tx({ADDR + 7'h1, 1'b0}, 1'b1);
    stop_cond();
    rd(8'h40, d);
    chk("readback", 32'(en_m), 32'(d));
    @(posedge clk);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    en_m = 4'hf;
    tick(5);
    chk("enables", 32'h0f, 32'(bank_enables));
    chk_p();
    gate(10);
    complete_run();
  end

  // Watchdog against a hung bus transfer; about three times the expected run length.
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    complete_run();
  end

endmodule : tb_top

//--- src/cgd_device_ctrl.sv
// Device control registers with their serial port slave and output bank gating.
// Notes on behaviour
// - A written 1 in the sync command pulses a divider resync, then clears.
// - A written 1 in the reacquire command pulses PLL lock reacquisition, then clears.
// - A written 1 in the calibration command pulses bias calibration, then clears.
// - The three command registers always read back as zero.
// - First bank enable resets to 1; when 0 outputs are true 0, complement 1.
// - Second bank enable resets to 1; when 0 outputs are true 0, complement 1.
// - Third bank enable resets to 1; when 0 outputs are true 0, complement 1.
// - Fourth bank enable resets to 1; when 0 diff goes low, single drives 0.
// - Either powerdown puts the single-ended fourth bank output in high impedance.
// - Reserved bits are written as zero; here they read as zero.
`timescale 1ns/1ps

module cgd_device_ctrl
  import cgd_pkg::*;
#(
  // Seven-bit serial port address; the value is arbitrary.
  parameter logic [6:0] DEV_ADDR = 7'h2a
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire cgd_bank_src_t bank_src,
  input wire logic fourth_bank_powerdown,
  input wire logic single_ended_output_powerdown,
  output logic divider_sync_pulse,
  output logic pll_reacquire_trigger,
  output logic bias_calibration_trigger,
  output logic [3:0] bank_enables,
  output cgd_bank_out_t bank_out
);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    cgd_i2c_st_t st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic drive;
    logic [3:0] en;
    logic sync_p;
    logic reacq_p;
    logic cal_p;
    cgd_bank_out_t outs;
  } cgd_state_t;

  cgd_state_t st;
  cgd_state_t next_st;

  // Read value of a register; commands and reserved bits read as zero.
  function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [3:0] en);
    logic [7:0] v;
    v = 8'h00;
    if (addr == CGD_REG_ENABLES)
    begin
      v = {4'h0, en};
    end
    return v;
  endfunction : read_reg

  // True side of a gated bank: held low while disabled.
  function automatic logic [3:0] gate_true(input logic en, input logic [3:0] src);
    return en ? src : 4'h0;
  endfunction : gate_true

  // Complement side of a gated bank: held high while disabled.
  function automatic logic [3:0] gate_comp(input logic en, input logic [3:0] src);
    return en ? ~src : 4'hf;
  endfunction : gate_comp

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic wr_now;
  logic load_rd;

  // Bus events come from the second synchroniser stage and its delayed copy only.
  assign scl_rise = st.scl_s2 && !st.scl_d;
  assign scl_fall = !st.scl_s2 && st.scl_d;
  assign start_cond = st.scl_s2 && st.scl_d && st.sda_d && !st.sda_s2;
  assign stop_cond = st.scl_s2 && st.scl_d && !st.sda_d && st.sda_s2;
  assign wr_now = scl_fall && (st.st == CGD_ST_WDATA) && (st.cnt == CGD_BITS_PER_BYTE);
  assign load_rd = scl_fall && (((st.st == CGD_ST_ACK_ADDR) && st.rw)
                   || ((st.st == CGD_ST_RACK) && !st.nack));

  // Next-state logic for the serial slave, the register file and the bank gates.
  always_comb
  begin
    next_st = st;
    next_st.scl_s1 = scl_in;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_d = st.scl_s2;
    next_st.sda_s1 = sda_in;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_d = st.sda_s2;
    // Command pulses last one cycle, so the bits are never seen as set.
    next_st.sync_p = 1'b0;
    next_st.reacq_p = 1'b0;
    next_st.cal_p = 1'b0;
    if (stop_cond)
    begin
      next_st.st = CGD_ST_IDLE;
      next_st.drive = 1'b0;
    end
    else if (start_cond)
    begin
      // A repeated start is accepted in any state and keeps the pointer.
      next_st.st = CGD_ST_ADDR;
      next_st.cnt = 4'h0;
      next_st.drive = 1'b0;
    end
    else if (scl_rise)
    begin
      case (st.st)
        CGD_ST_ADDR, CGD_ST_REG, CGD_ST_WDATA:
        begin
          next_st.shift = {st.shift[6:0], st.sda_s2};
          next_st.cnt = st.cnt + 4'h1;
        end
        CGD_ST_RDATA:
        begin
          next_st.cnt = st.cnt + 4'h1;
        end
        CGD_ST_RACK:
        begin
          next_st.nack = st.sda_s2;
        end
        default:
        begin
          next_st.cnt = st.cnt;
        end
      endcase
    end
    else if (scl_fall)
    begin
      case (st.st)
        CGD_ST_ADDR:
        begin
          if (st.cnt == CGD_BITS_PER_BYTE)
          begin
            if (st.shift[7:1] == DEV_ADDR)
            begin
              next_st.rw = st.shift[0];
              next_st.st = CGD_ST_ACK_ADDR;
              next_st.drive = 1'b1;
            end
            else
            begin
              next_st.st = CGD_ST_IDLE;
            end
          end
        end
        CGD_ST_ACK_ADDR:
        begin
          next_st.cnt = 4'h0;
          if (st.rw)
          begin
            next_st.shift = read_reg(st.ptr, st.en);
            next_st.drive = ~next_st.shift[7];
            next_st.st = CGD_ST_RDATA;
          end
          else
          begin
            next_st.drive = 1'b0;
            next_st.st = CGD_ST_REG;
          end
        end
        CGD_ST_REG:
        begin
          if (st.cnt == CGD_BITS_PER_BYTE)
          begin
            next_st.ptr = st.shift;
            next_st.st = CGD_ST_ACK_REG;
            next_st.drive = 1'b1;
          end
        end
        CGD_ST_WDATA:
        begin
          if (st.cnt == CGD_BITS_PER_BYTE)
          begin
            // Only a written 1 fires a command; a 0 does nothing.
            case (st.ptr)
              CGD_REG_SYNC: next_st.sync_p = st.shift[CGD_CMD_BIT];
              CGD_REG_REACQ: next_st.reacq_p = st.shift[CGD_CMD_BIT];
              CGD_REG_CAL: next_st.cal_p = st.shift[CGD_CMD_BIT];
              CGD_REG_ENABLES: next_st.en = st.shift[3:0];
              default: next_st.en = st.en;
            endcase
            next_st.ptr = st.ptr + 8'h01;
            next_st.st = CGD_ST_ACK_W;
            next_st.drive = 1'b1;
          end
        end
        CGD_ST_ACK_REG, CGD_ST_ACK_W:
        begin
          next_st.cnt = 4'h0;
          next_st.drive = 1'b0;
          next_st.st = CGD_ST_WDATA;
        end
        CGD_ST_RDATA:
        begin
          if (st.cnt == CGD_BITS_PER_BYTE)
          begin
            next_st.drive = 1'b0;
            next_st.ptr = st.ptr + 8'h01;
            next_st.st = CGD_ST_RACK;
          end
          else
          begin
            next_st.shift = {st.shift[6:0], 1'b0};
            next_st.drive = ~st.shift[6];
          end
        end
        CGD_ST_RACK:
        begin
          next_st.cnt = 4'h0;
          if (st.nack)
          begin
            next_st.st = CGD_ST_IDLE;
          end
          else
          begin
            next_st.shift = read_reg(st.ptr, st.en);
            next_st.drive = ~next_st.shift[7];
            next_st.st = CGD_ST_RDATA;
          end
        end
        default:
        begin
          next_st.st = CGD_ST_IDLE;
        end
      endcase
    end
    // Disabled banks park in the logic-low state: true 0, complement 1.
    next_st.outs.first_bank_outputs = gate_true(st.en[CGD_EN_A_BIT], bank_src.a);
    next_st.outs.first_bank_outputs_comp = gate_comp(st.en[CGD_EN_A_BIT], bank_src.a);
    next_st.outs.second_bank_outputs = gate_true(st.en[CGD_EN_B_BIT], bank_src.b);
    next_st.outs.second_bank_outputs_comp = gate_comp(st.en[CGD_EN_B_BIT], bank_src.b);
    next_st.outs.third_bank_outputs = st.en[CGD_EN_C_BIT] ? bank_src.c : 2'h0;
    next_st.outs.third_bank_outputs_comp = st.en[CGD_EN_C_BIT] ? ~bank_src.c : 2'h3;
    next_st.outs.fourth_bank_diff_output = st.en[CGD_EN_D_BIT] && bank_src.d0;
    next_st.outs.fourth_bank_diff_output_comp = !st.en[CGD_EN_D_BIT] || !bank_src.d0;
    next_st.outs.fourth_bank_single_output = st.en[CGD_EN_D_BIT] && bank_src.d1;
    // Powerdown overrides the enable: the pin floats whatever the enable says.
    next_st.outs.fourth_bank_single_oe_n = fourth_bank_powerdown
      || single_ended_output_powerdown;
  end

  // One register stage for all state; reset parks every bank in its safe level.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.scl_s1 <= 1'b1;
      st.scl_s2 <= 1'b1;
      st.scl_d <= 1'b1;
      st.sda_s1 <= 1'b1;
      st.sda_s2 <= 1'b1;
      st.sda_d <= 1'b1;
      st.st <= CGD_ST_IDLE;
      st.ptr <= CGD_PTR_RESET;
      st.en <= CGD_EN_RESET;
      st.outs.first_bank_outputs_comp <= 4'hf;
      st.outs.second_bank_outputs_comp <= 4'hf;
      st.outs.third_bank_outputs_comp <= 2'h3;
      st.outs.fourth_bank_diff_output_comp <= 1'b1;
      st.outs.fourth_bank_single_oe_n <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Open-drain data line: only ever pulled low.
  assign sda_out = 1'b0;
  assign sda_oe_n = ~st.drive;
  assign divider_sync_pulse = st.sync_p;
  assign pll_reacquire_trigger = st.reacq_p;
  assign bias_calibration_trigger = st.cal_p;
  assign bank_enables = st.en;
  assign bank_out = st.outs;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Command writes and their pulses, register reads, bank parking and powerdown.
  chk_sync_fires: assert property (wr_now && st.ptr == CGD_REG_SYNC && st.shift[7]
    |=> divider_sync_pulse ##1 !divider_sync_pulse) else $error("sync pulse wrong");
  chk_reacq_fires: assert property (wr_now && st.ptr == CGD_REG_REACQ && st.shift[7]
    |=> pll_reacquire_trigger ##1 !pll_reacquire_trigger) else $error("reacquire wrong");
  chk_cal_fires: assert property (wr_now && st.ptr == CGD_REG_CAL && st.shift[7]
    |=> bias_calibration_trigger ##1 !bias_calibration_trigger) else $error("cal wrong");
  chk_zero_write_idle: assert property (wr_now && !st.shift[7]
    |=> !divider_sync_pulse && !pll_reacquire_trigger && !bias_calibration_trigger)
    else $error("zero write fired");
  chk_cmd_read_zero: assert property (load_rd && (st.ptr == CGD_REG_SYNC
    || st.ptr == CGD_REG_REACQ || st.ptr == CGD_REG_CAL) |=> st.shift == 8'h00)
    else $error("command read not zero");
  chk_rsvd_read_zero: assert property (load_rd && st.ptr == CGD_REG_ENABLES
    |=> st.shift[7:4] == 4'h0 && st.shift[3:0] == $past(st.en)) else $error("bad read");
  chk_bank_a_park: assert property (!st.en[CGD_EN_A_BIT] |=> bank_out.first_bank_outputs
    == 4'h0 && bank_out.first_bank_outputs_comp == 4'hf) else $error("bank a");
  chk_bank_b_park: assert property (!st.en[CGD_EN_B_BIT] |=> bank_out.second_bank_outputs
    == 4'h0 && bank_out.second_bank_outputs_comp == 4'hf) else $error("bank b");
  chk_bank_c_park: assert property (!st.en[CGD_EN_C_BIT] |=> bank_out.third_bank_outputs
    == 2'h0 && bank_out.third_bank_outputs_comp == 2'h3) else $error("bank c");
  chk_bank_d_park: assert property (!st.en[CGD_EN_D_BIT] |=>
    !bank_out.fourth_bank_diff_output && bank_out.fourth_bank_diff_output_comp
    && !bank_out.fourth_bank_single_output) else $error("bank d");
  chk_single_hiz: assert property (fourth_bank_powerdown
    || single_ended_output_powerdown |=> bank_out.fourth_bank_single_oe_n)
    else $error("single not floating");

  cov_sync: cover property (divider_sync_pulse);
  cov_reacq: cover property (pll_reacquire_trigger);
  cov_cal: cover property (bias_calibration_trigger);
  cov_disable: cover property (wr_now && st.ptr == CGD_REG_ENABLES && st.shift[3:0] == 4'h0);

endmodule : cgd_device_ctrl

//--- src/cgd_pkg.sv
// Shared constants and types for the clock generator device control registers.
package cgd_pkg;

  // Register offsets on the serial port.
  localparam logic [7:0] CGD_REG_SYNC = 8'h3d;
  localparam logic [7:0] CGD_REG_REACQ = 8'h3e;
  localparam logic [7:0] CGD_REG_CAL = 8'h3f;
  localparam logic [7:0] CGD_REG_ENABLES = 8'h40;

  // Field positions.
  localparam int CGD_CMD_BIT = 7;
  localparam int CGD_EN_A_BIT = 3;
  localparam int CGD_EN_B_BIT = 2;
  localparam int CGD_EN_C_BIT = 1;
  localparam int CGD_EN_D_BIT = 0;

  // Reset values.
  localparam logic [3:0] CGD_EN_RESET = 4'hf;
  localparam logic [7:0] CGD_PTR_RESET = 8'h00;

  // Serial port timing: bits per byte.
  localparam logic [3:0] CGD_BITS_PER_BYTE = 4'h8;

  // Serial port states, one-hot.
  typedef enum logic [8:0] {
    CGD_ST_IDLE = 9'h001,
    CGD_ST_ADDR = 9'h002,
    CGD_ST_ACK_ADDR = 9'h004,
    CGD_ST_REG = 9'h008,
    CGD_ST_ACK_REG = 9'h010,
    CGD_ST_WDATA = 9'h020,
    CGD_ST_ACK_W = 9'h040,
    CGD_ST_RDATA = 9'h080,
    CGD_ST_RACK = 9'h100
  } cgd_i2c_st_t;

  // Clock sources arriving from the output dividers.
  typedef struct packed {
    logic [3:0] a;
    logic [3:0] b;
    logic [1:0] c;
    logic d0;
    logic d1;
  } cgd_bank_src_t;

  // Gated output levels toward the output drivers.
  typedef struct packed {
    logic [3:0] first_bank_outputs;
    logic [3:0] first_bank_outputs_comp;
    logic [3:0] second_bank_outputs;
    logic [3:0] second_bank_outputs_comp;
    logic [1:0] third_bank_outputs;
    logic [1:0] third_bank_outputs_comp;
    logic fourth_bank_diff_output;
    logic fourth_bank_diff_output_comp;
    logic fourth_bank_single_output;
    logic fourth_bank_single_oe_n;
  } cgd_bank_out_t;

endpackage : cgd_pkg
